//--- design/ebu_regs.vh
`ifndef EBU_REGS_VH
`define EBU_REGS_VH
// ----------------------------------------
// bus geometry
// ----------------------------------------
`define EBU_ADDR_W        24
`define EBU_DATA_W        16
`define EBU_SEG_W         8
`define EBU_WIN_N         4
`define EBU_REG_N         5
`define EBU_WAIT_W        4
`define EBU_WIN_CMP_W     16
// ----------------------------------------
// reference clock timing
// ----------------------------------------
`define EBU_CORE_PERIOD_NS 8
`define EBU_REF_PERIOD_NS  160
`define EBU_REF_HALF       ((`EBU_REF_PERIOD_NS / `EBU_CORE_PERIOD_NS) / 2)
// ----------------------------------------
// region indices and reset values
// ----------------------------------------
`define EBU_REGION_DEF    3'h0
`define EBU_CS_IDLE       5'h1f
`define EBU_SEG_LINES_W   3
`endif

//--- design/ebu_rsp_buf.v
`timescale 1ns/100ps
// ----------------------------------------
// two-entry response buffer, registered outputs
// ----------------------------------------
module ebu_rsp_buf #(
  parameter W = 16
) (
  input  wire         core_clk,
  input  wire         srst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg         head_v_q;
  reg [W-1:0] head_q;
  reg         spare_v_q;
  reg [W-1:0] spare_q;
  wire        push;
  wire        pop;

  // spare slot absorbs a word while the drain side stalls
  assign in_ready  = ~spare_v_q;
  assign out_valid = head_v_q;
  assign out_data  = head_q;
  assign push      = in_valid & ~spare_v_q;
  assign pop       = head_v_q & out_ready;

  // head refills from spare first so order is kept
  always @(posedge core_clk) begin
    if (srst) begin
      head_v_q  <= 1'b0;
      head_q    <= {W{1'b0}};
      spare_v_q <= 1'b0;
      spare_q   <= {W{1'b0}};
    end else if (~head_v_q | pop) begin
      if (spare_v_q) begin
        head_v_q  <= 1'b1;
        head_q    <= spare_q;
        spare_v_q <= push;
        if (push) spare_q <= in_data;
      end else begin
        head_v_q <= push;
        if (push) head_q <= in_data;
      end
    end else if (push) begin
      spare_v_q <= 1'b1;
      spare_q   <= in_data;
    end
  end
endmodule

//--- design/ebu_ext_bus_unit.v
`timescale 1ns/100ps
`include "ebu_regs.vh"
module ebu_ext_bus_unit (
  input  wire                       core_clk,
  input  wire                       srst,
  input  wire                       req_valid,
  output reg                        req_ready,
  input  wire [`EBU_ADDR_W-1:0]     req_addr,
  input  wire                       req_write,
  input  wire [`EBU_DATA_W-1:0]     req_wdata,
  output wire                       rsp_valid,
  input  wire                       rsp_ready,
  output wire [`EBU_DATA_W-1:0]     rsp_rdata,
  input  wire                       single_chip,
  input  wire [`EBU_SEG_LINES_W-1:0] seg_lines,
  input  wire                       ready_active_high,
  input  wire                       arb_enable,
  input  wire                       arb_slave,
  input  wire [`EBU_WIN_N-1:0]      win_enable,
  input  wire [4*`EBU_WIN_CMP_W-1:0] window_address_select,
  input  wire [4*`EBU_WIN_CMP_W-1:0] window_address_mask,
  input  wire [5*`EBU_WAIT_W-1:0]   window_timing_cfg,
  input  wire [`EBU_REG_N-1:0]      window_ready_en,
  input  wire [`EBU_REG_N-1:0]      window_function_mux,
  input  wire [`EBU_REG_N-1:0]      window_function_bus8,
  output reg                        bus_reference_clock,
  output reg  [`EBU_DATA_W-1:0]     addr_data_port_o,
  output reg                        addr_data_port_oe,
  input  wire [`EBU_DATA_W-1:0]     addr_data_port_i,
  output reg  [`EBU_DATA_W-1:0]     address_port,
  output reg  [`EBU_SEG_W-1:0]      segment_port,
  output reg                        bus_oe,
  output reg  [`EBU_REG_N-1:0]      cs_n,
  output reg                        rd_n,
  output reg                        wr_n,
  output reg                        ale,
  input  wire                       ready_in,
  input  wire                       hold_in,
  output reg                        hold_acknowledge_o,
  output reg                        hold_acknowledge_oe,
  input  wire                       hold_acknowledge_i,
  output reg                        bus_request_out
);
  // ----------------------------------------
  // states and constants
  // ----------------------------------------
  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_STROBE = 3'h2;
  localparam [2:0] ST_END    = 3'h3;
  localparam [2:0] ST_HOLD   = 3'h4;
  localparam integer REF_HALF_I = `EBU_REF_HALF;
  localparam [7:0]   REF_HALF   = REF_HALF_I[7:0];

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // window compare on address bits 23..8
  function win_hit;
    input [`EBU_ADDR_W-1:0]   a;
    input [`EBU_WIN_CMP_W-1:0] base;
    input [`EBU_WIN_CMP_W-1:0] mask;
    begin
      win_hit = (((a[23:8] ^ base) & mask) == 16'h0000);
    end
  endfunction

  // prioritised region pick, 0 is the default region
  function [2:0] pick_region;
    input [`EBU_ADDR_W-1:0] a;
    input [3:0]             en;
    input [63:0]            base;
    input [63:0]            mask;
    begin
      if (en[3] & win_hit(a, base[63:48], mask[63:48]))
        pick_region = 3'h4;
      else if (en[2] & win_hit(a, base[47:32], mask[47:32]))
        pick_region = 3'h3;
      else if (en[1] & win_hit(a, base[31:16], mask[31:16]))
        pick_region = 3'h2;
      else if (en[0] & win_hit(a, base[15:0], mask[15:0]))
        pick_region = 3'h1;
      else
        pick_region = `EBU_REGION_DEF;
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg        rdy_m_q, rdy_s_q;
  reg        hold_m_q, hold_s_q;
  reg        hack_m_q, hack_s_q;
  reg [15:0] ad_m_q, ad_s_q;

  // pins are asynchronous to core_clk: two flops each
  always @(posedge core_clk) begin
    if (srst) begin
      rdy_m_q  <= 1'b0;
      rdy_s_q  <= 1'b0;
      hold_m_q <= 1'b0;
      hold_s_q <= 1'b0;
      hack_m_q <= 1'b0;
      hack_s_q <= 1'b0;
      ad_m_q   <= 16'h0000;
      ad_s_q   <= 16'h0000;
    end else begin
      rdy_m_q  <= ready_in;
      rdy_s_q  <= rdy_m_q;
      hold_m_q <= hold_in;
      hold_s_q <= hold_m_q;
      hack_m_q <= hold_acknowledge_i;
      hack_s_q <= hack_m_q;
      ad_m_q   <= addr_data_port_i;
      ad_s_q   <= ad_m_q;
    end
  end

  // ----------------------------------------
  // reference clock divider
  // ----------------------------------------
  reg  [7:0] div_q;
  wire       tick;

  // tick marks the core edge on which the reference clock rises
  assign tick = (div_q == REF_HALF - 8'h01) & ~bus_reference_clock;

  always @(posedge core_clk) begin
    if (srst) begin
      div_q               <= 8'h00;
      bus_reference_clock <= 1'b0;
    end else if (div_q == REF_HALF - 8'h01) begin
      div_q               <= 8'h00;
      bus_reference_clock <= ~bus_reference_clock;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------
  // request capture and response buffer
  // ----------------------------------------
  reg  [2:0]  st_q;
  reg         pend_q;
  reg  [23:0] a_q;
  reg         wr_q;
  reg  [15:0] wd_q;
  reg  [15:0] rd_q;
  reg         push_q;
  wire        buf_ready;
  wire        accept;
  wire        rdy_act;
  wire        owned;
  wire        push_d;
  wire        pend_d;

  assign accept  = req_valid & req_ready;
  assign push_d  = tick & (st_q == ST_END);
  assign pend_d  = accept | (pend_q & ~push_d);
  assign rdy_act = ~(rdy_s_q ^ ready_active_high);
  // slave owns the bus only while the master grants it
  assign owned   = ~(arb_enable & arb_slave) | hack_s_q;

  // single-chip mode accepts no external access after its first cycle, as req_ready is registered
  always @(posedge core_clk) begin
    if (srst) begin
      pend_q    <= 1'b0;
      req_ready <= 1'b0;
      a_q       <= 24'h000000;
      wr_q      <= 1'b0;
      wd_q      <= 16'h0000;
    end else begin
      pend_q    <= pend_d;
      req_ready <= ~pend_d & ~push_d & ~push_q & buf_ready & ~single_chip;
      if (accept) begin
        a_q  <= req_addr;
        wr_q <= req_write;
        wd_q <= req_wdata;
      end
    end
  end

  ebu_rsp_buf #(
    .W (`EBU_DATA_W)
  ) u_rsp_buf (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (push_q),
    .in_ready  (buf_ready),
    .in_data   (rd_q),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_rdata)
  );

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  reg [2:0] reg_q;
  reg [3:0] wait_q;
  wire [2:0] reg_d;
  wire [7:0] seg_mask;

  assign reg_d    = pick_region(a_q, win_enable, window_address_select,
                                window_address_mask);
  assign seg_mask = (8'h01 << seg_lines) - 8'h01;

  // every pin update waits for tick, the rising reference edge
  always @(posedge core_clk) begin
    if (srst) begin
      st_q              <= ST_IDLE;
      reg_q             <= `EBU_REGION_DEF;
      wait_q            <= 4'h0;
      rd_q              <= 16'h0000;
      push_q            <= 1'b0;
      addr_data_port_o  <= 16'h0000;
      addr_data_port_oe <= 1'b0;
      address_port      <= 16'h0000;
      segment_port      <= 8'h00;
      bus_oe            <= 1'b1;
      cs_n              <= `EBU_CS_IDLE;
      rd_n              <= 1'b1;
      wr_n              <= 1'b1;
      ale               <= 1'b0;
    end else begin
      push_q <= push_d;
      if (tick) begin
        case (st_q)
          ST_IDLE: begin
            bus_oe <= owned;
            if (arb_enable & ~arb_slave & hold_s_q) begin
              st_q   <= ST_HOLD;
              bus_oe <= 1'b0;
            end else if (pend_q & owned) begin
              st_q         <= ST_ADDR;
              reg_q        <= reg_d;
              bus_oe       <= 1'b1;
              cs_n         <= ~(5'h01 << reg_d);
              ale          <= 1'b1;
              segment_port <= a_q[23:16] & seg_mask;
              address_port <= a_q[15:0];
              // mode follows the window of this access
              if (window_function_mux[reg_d]) begin
                addr_data_port_o  <= a_q[15:0];
                addr_data_port_oe <= 1'b1;
              end else begin
                addr_data_port_oe <= 1'b0;
              end
            end
          end
          ST_ADDR: begin
            st_q   <= ST_STROBE;
            ale    <= 1'b0;
            wait_q <= window_timing_cfg[reg_q*4 +: 4];
            if (wr_q) begin
              wr_n              <= 1'b0;
              addr_data_port_oe <= 1'b1;
              // 8-bit bus carries only the low byte, the high byte is driven as zero
              if (window_function_bus8[reg_q])
                addr_data_port_o <= {8'h00, wd_q[7:0]};
              else
                addr_data_port_o <= wd_q;
            end else begin
              rd_n              <= 1'b0;
              addr_data_port_oe <= 1'b0;
            end
          end
          ST_STROBE: begin
            if (wait_q != 4'h0) begin
              wait_q <= wait_q - 4'h1;
            end else if (~window_ready_en[reg_q] | rdy_act) begin
              st_q <= ST_END;
              rd_n <= 1'b1;
              wr_n <= 1'b1;
              rd_q <= wr_q ? 16'h0000 : (window_function_bus8[reg_q] ? {8'h00, ad_s_q[7:0]} : ad_s_q);
            end
          end
          ST_END: begin
            st_q              <= ST_IDLE;
            cs_n              <= `EBU_CS_IDLE;
            addr_data_port_oe <= 1'b0;
          end
          ST_HOLD: begin
            // stay floated on exit so acknowledge drops before lines return
            bus_oe            <= 1'b0;
            addr_data_port_oe <= 1'b0;
            if (~hold_s_q | ~arb_enable | arb_slave) begin
              st_q <= ST_IDLE;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // arbitration pins
  // ----------------------------------------
  // pins stay passive until software enables arbitration
  always @(posedge core_clk) begin
    if (srst) begin
      hold_acknowledge_o  <= 1'b0;
      hold_acknowledge_oe <= 1'b1;
      bus_request_out     <= 1'b0;
    end else if (~arb_enable) begin
      hold_acknowledge_o  <= 1'b0;
      hold_acknowledge_oe <= ~arb_slave;
      bus_request_out     <= 1'b0;
    end else if (arb_slave) begin
      hold_acknowledge_o  <= 1'b0;
      hold_acknowledge_oe <= 1'b0;
      bus_request_out     <= pend_q & ~hack_s_q;
    end else begin
      hold_acknowledge_oe <= 1'b1;
      hold_acknowledge_o  <= (st_q == ST_HOLD) & ~bus_oe;
      bus_request_out     <= pend_q & (st_q == ST_HOLD);
    end
  end
endmodule

//--- tb/ebu_chk.sv
`timescale 1ns/100ps
// ----------------------------------------
// pin-level checker for the bus unit
// ----------------------------------------
module ebu_chk (
  input wire        core_clk,
  input wire        srst,
  input wire        single_chip,
  input wire        arb_enable,
  input wire        arb_slave,
  input wire        req_ready,
  input wire        bus_reference_clock,
  input wire        addr_data_port_oe,
  input wire        bus_oe,
  input wire [4:0]  cs_n,
  input wire        rd_n,
  input wire        wr_n,
  input wire        ale,
  input wire        hold_acknowledge_o,
  input wire        hold_acknowledge_oe,
  input wire        bus_request_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // one region at a time, strobes only inside a selected access
  a_cs_single: assert property ($countones(~cs_n) <= 1)
    else $error("two chip selects low");
  a_strobe_cs: assert property (!rd_n || !wr_n |-> cs_n != 5'h1f && rd_n != wr_n)
    else $error("strobe without chip select");
  // reference clock is 10 high, 10 low; bus events start on its rise
  a_ref_half: assert property ($rose(bus_reference_clock) |-> bus_reference_clock[*8]
                               ##1 bus_reference_clock[*2] ##1 !bus_reference_clock)
    else $error("reference clock high phase wrong");
  a_ev_on_tick: assert property ($rose(ale) || $fell(rd_n) || $fell(wr_n) |-> $rose(bus_reference_clock))
    else $error("bus event off the reference rise");
  a_chip_refuse: assert property (single_chip && $past(single_chip) |-> !req_ready)
    else $error("request accepted in single chip mode");
  a_arb_off: assert property (!$past(arb_enable) |-> !bus_request_out)
    else $error("bus request while arbitration off");
  a_master_ack: assert property (!$past(arb_slave) |-> hold_acknowledge_oe)
    else $error("acknowledge not driven as master");
  a_slave_ack: assert property ($past(arb_enable) && $past(arb_slave) |-> !hold_acknowledge_oe)
    else $error("acknowledge driven as slave");
  // a granted hold leaves every line floated and no region selected
  a_hold_float: assert property (hold_acknowledge_o && hold_acknowledge_oe |-> !bus_oe && !addr_data_port_oe
                                 && cs_n == 5'h1f)
    else $error("lines driven during hold");
endmodule
bind ebu_ext_bus_unit ebu_chk u_chk (.*);

//--- tb/ebu_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// external memory with a slow ready
// ----------------------------------------
module ebu_mem_model (
  input wire          core_clk,
  input wire          mux,
  input wire [7:0]    dly,
  input wire          pol,
  input wire [15:0]   ad_o,
  input wire          ad_oe,
  input wire [15:0]   addr,
  input wire [7:0]    seg,
  input wire [4:0]    cs_n,
  input wire          rd_n,
  input wire          wr_n,
  input wire          ale,
  output logic [15:0] ad_i,
  output logic        rdy
);
  logic [15:0] mem [16];
  logic [15:0] lat = 16'h0, last = 16'h0;
  logic [7:0]  seg_q = 8'h0;
  logic [4:0]  cs_q = 5'h1f;
  int          strb = 0, len = 0;
  wire [3:0]   idx = mux ? lat[3:0] : addr[3:0];
  wire         act = !rd_n || !wr_n;
  // address phase, strobe length and write capture
  always @(posedge core_clk) begin
    if (ale) begin
      lat <= ad_o;
      seg_q <= seg;
    end
    if (act) begin
      strb <= strb + 1;
      cs_q <= cs_n;
    end else if (strb != 0) begin
      len <= strb;
      strb <= 0;
    end
    if (!wr_n) mem[idx] <= ad_o;
    last <= ad_i;
  end
  // ready stays inactive until dly strobe cycles have passed
  assign rdy = (act && strb >= dly) ? pol : !pol;
  // released bus toggles every cycle so stale data never matches
  assign ad_i = ad_oe ? ad_o : (!rd_n ? mem[idx] : ~last);
endmodule

//--- tb/ebu_ext_bus_unit_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module ebu_ext_bus_unit_test;
  logic        core_clk = 1'b0, srst = 1'b1, req_valid = 1'b0, req_write = 1'b0, rsp_ready = 1'b0;
  logic        single_chip = 1'b0, ready_active_high = 1'b1, arb_enable = 1'b0, arb_slave = 1'b0;
  logic        hold_in = 1'b0, ack_drv = 1'b0, mdl_mux = 1'b0;
  logic [23:0] req_addr = 24'h0;
  logic [15:0] req_wdata = 16'h0, q;
  logic [2:0]  seg_lines = 3'h7;
  logic [3:0]  win_enable = 4'h0;
  logic [63:0] window_address_select = 64'h0, window_address_mask = 64'h0;
  logic [19:0] window_timing_cfg = 20'h0;
  logic [4:0]  window_ready_en = 5'h0, window_function_mux = 5'h0, window_function_bus8 = 5'h0;
  logic [7:0]  mdl_dly = 8'h0;
  int          n_fail = 0, n_checks = 0;
  wire         req_ready, rsp_valid, bus_reference_clock, addr_data_port_oe, bus_oe, rd_n, wr_n, ale;
  wire         hold_acknowledge_o, hold_acknowledge_oe, bus_request_out, ready_in;
  wire [15:0]  rsp_rdata, addr_data_port_o, addr_data_port_i, address_port;
  wire [7:0]   segment_port;
  wire [4:0]   cs_n;
  // acknowledge pin: whoever enables drives it
  wire         hold_acknowledge_i = hold_acknowledge_oe ? hold_acknowledge_o : ack_drv;
  always #4 core_clk = ~core_clk;
  ebu_ext_bus_unit uut (.*);
  ebu_mem_model m (.core_clk(core_clk), .mux(mdl_mux), .dly(mdl_dly), .pol(ready_active_high),
    .ad_o(addr_data_port_o), .ad_oe(addr_data_port_oe), .addr(address_port), .seg(segment_port),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ale(ale), .ad_i(addr_data_port_i), .rdy(ready_in));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic issue(input logic [23:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req_addr <= a;
    req_write <= w;
    req_wdata <= d;
    req_valid <= 1'b1;
    do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 500);
    `CHK("accept", 1'b1, req_ready)
    req_valid <= 1'b0;
  endtask
  task automatic take(output logic [15:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    rsp_ready <= 1'b1;
    do begin @(posedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 2000);
    `CHK("response", 1'b1, rsp_valid)
    r = rsp_rdata;
    rsp_ready <= 1'b0;
  endtask
  task automatic acc(input logic [23:0] a, input logic w, input logic [15:0] d, output logic [15:0] r);
    issue(a, w, d);
    take(r);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    `CHK("cs_rst", 5'h1f, cs_n)
    `CHK("ack_oe_rst", 1'b1, hold_acknowledge_oe)
    srst <= 1'b0;
    single_chip <= 1'b1;
    req_valid <= 1'b1;
    repeat (100) @(posedge core_clk);
    `CHK("sc_refuse", 1'b0, req_ready)
    single_chip <= 1'b0;
    req_valid <= 1'b0;
    $display("single chip done");
    // default region, wait counts of 0 and 2 ref periods
    for (int w = 0; w < 3; w += 2) begin
      window_timing_cfg <= 20'(w);
      acc(24'h000004 + 24'(w), 1'b1, 16'h1234 + 16'(w), q);
      `CHK("wait_len", 20 * (w + 1), m.len)
      `CHK("cs_def", 5'h1e, m.cs_q)
      acc(24'h000004 + 24'(w), 1'b0, 16'h0, q);
      `CHK("rd16", 16'h1234 + 16'(w), q)
    end
    $display("default region done");
    // overlapping windows: highest enabled one wins
    window_timing_cfg <= 20'h0;
    window_address_select <= {4{16'hd500}};
    window_address_mask <= {4{16'hffff}};
    for (int k = 1; k < 5; k++) begin
      win_enable <= 4'((1 << k) - 1);
      seg_lines <= 3'(k + 3);
      acc(24'hd50008 + 24'(k), 1'b1, 16'h0, q);
      `CHK("win_cs", 5'h1f ^ (5'h1 << k), m.cs_q)
      `CHK("segment", 8'hd5 & ((8'h1 << (k + 3)) - 8'h1), m.seg_q)
    end
    $display("windows done");
    // multiplexed 8-bit window, then back to the demultiplexed default
    seg_lines <= 3'h7;
    win_enable <= 4'h1;
    window_function_mux <= 5'h02;
    window_function_bus8 <= 5'h02;
    mdl_mux <= 1'b1;
    acc(24'hd50009, 1'b1, 16'hbeef, q);
    `CHK("mux_addr", 16'h0009, m.lat)
    acc(24'hd50009, 1'b0, 16'h0, q);
    `CHK("rd8", 16'h00ef, q)
    mdl_mux <= 1'b0;
    acc(24'h000009, 1'b0, 16'h0, q);
    `CHK("mode_swap", 8'hef, q[7:0])
    $display("bus modes done");
    // slow device, ready of either polarity
    win_enable <= 4'h0;
    window_ready_en <= 5'h01;
    mdl_dly <= 8'd50;
    for (int p = 0; p < 2; p++) begin
      ready_active_high <= p[0];
      acc(24'h000002, 1'b0, 16'h0, q);
      `CHK("rdy_len", 1'b1, m.len >= 60 && m.len % 20 == 0)
    end
    window_ready_en <= 5'h0;
    mdl_dly <= 8'd0;
    $display("ready done");
    // two responses fill the buffer, a third request is refused
    issue(24'h000004, 1'b0, 16'h0);
    issue(24'h000006, 1'b1, 16'h5a5a);
    repeat (200) @(posedge core_clk);
    req_valid <= 1'b1;
    repeat (100) @(posedge core_clk);
    `CHK("buf_full", 1'b0, req_ready)
    req_valid <= 1'b0;
    take(q);
    `CHK("buf_first", 16'h1234, q)
    take(q);
    `CHK("buf_second", 16'h0000, q)
    acc(24'h000006, 1'b0, 16'h0, q);
    `CHK("buf_after", 16'h5a5a, q)
    $display("buffer done");
    // master: external master holds the bus while an access waits
    arb_enable <= 1'b1;
    hold_in <= 1'b1;
    repeat (60) @(posedge core_clk);
    `CHK("hold_ack", 1'b1, hold_acknowledge_o)
    `CHK("float", 1'b0, bus_oe)
    issue(24'h000004, 1'b0, 16'h0);
    repeat (40) @(posedge core_clk);
    `CHK("req_out_m", 1'b1, bus_request_out)
    `CHK("cs_held", 5'h1f, cs_n)
    hold_in <= 1'b0;
    take(q);
    `CHK("after_hold", 16'h1234, q)
    // slave: bus owned only while the master grants it
    arb_slave <= 1'b1;
    repeat (20) @(posedge core_clk);
    `CHK("unowned", 1'b0, bus_oe)
    issue(24'h000006, 1'b0, 16'h0);
    repeat (40) @(posedge core_clk);
    `CHK("req_out_s", 1'b1, bus_request_out)
    ack_drv <= 1'b1;
    take(q);
    `CHK("slave_rd", 16'h5a5a, q)
    ack_drv <= 1'b0;
    arb_enable <= 1'b0;
    $display("arbitration done");
    repeat (10) @(posedge core_clk);
    complete_run;
  end
  // hang guard well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    n_fail++;
    complete_run;
  end
endmodule
